// ===== logic/dsw_consts.svh
// Offsets, field positions, reset values and limits of the status word builder
`ifndef DSW_CONSTS_SVH
`define DSW_CONSTS_SVH

`define DSW_ADDR_W 8
`define DSW_OFF_STATUS 8'h00
`define DSW_OFF_CTRL 8'h04
`define DSW_OFF_FREQ_LO 8'h08
`define DSW_OFF_FREQ_HI 8'h0c
`define DSW_OFF_TRQ_MOT 8'h10
`define DSW_OFF_TRQ_GEN 8'h14
`define DSW_OFF_DC_LO 8'h18
`define DSW_OFF_DC_HI 8'h1c
`define DSW_OFF_CMD 8'h20
`define DSW_OFF_EVENTS 8'h24

`define DSW_RST_CTRL 16'h0001
`define DSW_RST_FREQ_LO 16'h0000
`define DSW_RST_FREQ_HI 16'h4000
`define DSW_RST_TRQ 16'h4000
`define DSW_RST_DC_LO 16'h0000
`define DSW_RST_DC_HI 16'hffff
`define DSW_THERMAL_FULL 16'h0064

`define DSW_CTRL_PROFILE 0
`define DSW_EV_LINK 0
`define DSW_EV_TRIP 1

`define DSW_CMD_ON1 0
`define DSW_CMD_ON2 1
`define DSW_CMD_ON3 2
`define DSW_CMD_NOCOAST 3
`define DSW_CMD_RESET 7
`define DSW_CMD_VALID 10

`define DSW_ST_CTRL_RDY 0
`define DSW_ST_DRV_RDY 1
`define DSW_ST_ENABLE 2
`define DSW_ST_TRIP 3
`define DSW_ST_ON2 4
`define DSW_ST_ON3 5
`define DSW_ST_INHIBIT 6
`define DSW_ST_WARN 7
`define DSW_ST_SPEED 8
`define DSW_ST_BUS 9
`define DSW_ST_FREQ 10
`define DSW_ST_RUN 11
`define DSW_ST_AUTO 12
`define DSW_ST_VOLT 13
`define DSW_ST_TORQUE 14
`define DSW_ST_TIMER 15

`endif

// ===== logic/dsw_pkg.sv
// Types and helper functions of the status word builder
package dsw_pkg;
    typedef logic [15:0] dsw_word_t;
    typedef enum logic {DSW_INH_ACTIVE, DSW_INH_CLEAR} dsw_inh_state_t;

    function automatic logic dsw_in_window(input dsw_word_t v, input dsw_word_t lo,
                                           input dsw_word_t hi);
        dsw_in_window = ($signed(v) >= $signed(lo)) && ($signed(v) <= $signed(hi));
    endfunction

    function automatic dsw_word_t dsw_abs(input dsw_word_t v);
        dsw_abs = v[15] ? dsw_word_t'(-v) : v;
    endfunction
endpackage

// ===== logic/dsw_cmd_if.sv
// Accepted command word and its derived events, shared inside the builder
`timescale 1ns/1ps
interface dsw_cmd_if;
    logic [15:0] cmd;
    logic ack_pulse;
    logic start_inhibit;
    logic profile_std;
    modport latch (output cmd, output ack_pulse);
    modport inhibit (input cmd, input ack_pulse, input profile_std, output start_inhibit);
    modport owner (input cmd, input ack_pulse, input start_inhibit, output profile_std);
endinterface

// ===== logic/dsw_cmd_latch.sv
// Holds the last valid command word and flags the acknowledge edge
`timescale 1ns/1ps
`include "dsw_consts.svh"
module dsw_cmd_latch import dsw_pkg::*; (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [15:0] cmd_word_i,
    input wire logic cmd_valid_i,
    dsw_cmd_if.latch cmd_if
);
    dsw_word_t cmd_q;
    logic ack_q;
    // Words without the valid bit are dropped whole
    wire logic take = cmd_valid_i & cmd_word_i[`DSW_CMD_VALID]; // RQ19
    wire logic ack_d = take & cmd_word_i[`DSW_CMD_RESET] & ~cmd_q[`DSW_CMD_RESET];

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cmd_q <= 16'h0000;
            ack_q <= 1'b0;
        end else begin
            if (take) begin
                cmd_q <= cmd_word_i; // RQ20
            end
            ack_q <= ack_d;
        end
    end

    assign cmd_if.cmd = cmd_q;
    assign cmd_if.ack_pulse = ack_q;
endmodule // dsw_cmd_latch

// ===== logic/dsw_start_inhibit.sv
// Start-not-possible state under the standard drive profile
`timescale 1ns/1ps
`include "dsw_consts.svh"
module dsw_start_inhibit import dsw_pkg::*; (
    input wire logic clk_i,
    input wire logic resetn_i,
    dsw_cmd_if.inhibit cmd_if
);
    dsw_inh_state_t state_q, state_d;
    wire logic off23 = ~cmd_if.cmd[`DSW_CMD_ON2] | ~cmd_if.cmd[`DSW_CMD_ON3];
    wire logic set_ev = cmd_if.ack_pulse | off23; // RQ8
    wire logic clr_ev = ~cmd_if.cmd[`DSW_CMD_ON1] & cmd_if.cmd[`DSW_CMD_ON2]
                      & cmd_if.cmd[`DSW_CMD_ON3] & cmd_if.cmd[`DSW_CMD_VALID]; // RQ8

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            DSW_INH_ACTIVE: begin
                if (clr_ev && !set_ev) begin
                    state_d = DSW_INH_CLEAR;
                end
            end
            DSW_INH_CLEAR: begin
                if (set_ev) begin
                    state_d = DSW_INH_ACTIVE;
                end
            end
        endcase
    end

    // Power-up counts as a switch-on event, so reset enters the active state
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= DSW_INH_ACTIVE; // RQ8
        end else begin
            state_q <= state_d;
        end
    end

    assign cmd_if.start_inhibit = cmd_if.profile_std & (state_q == DSW_INH_ACTIVE); // RQ8
endmodule // dsw_start_inhibit

// ===== logic/dsw_top.sv
// Drive status word builder: condition flags and command mirror into one word
//
// What this block does
// RQ1: Reports drive state as one 16-bit status word, bits 00 to 15.
// RQ2: Bit 00 low if command bits 00-02 low or tripped, else high.
// RQ3: Bit 01 as bit 00, and also needs the power unit supplied.
// RQ4: Bit 02 high only with command bits 00-03 high and no trip.
// RQ5: Bit 03 shows trip; trip holds until a reset acknowledge.
// RQ6: Bit 04 mirrors command bit 01.
// RQ7: Bit 05 mirrors command bit 02.
// RQ8: Bit 06 start inhibit set by ack, stops, power-up; cleared by command pattern.
// RQ9: Bit 07 shows any active warning.
// RQ10: Bit 08 high when motor speed matches its reference.
// RQ11: Bit 09 high when bus control is possible, low on local control.
// RQ12: Bit 10 high while output frequency is within warning limits.
// RQ13: Bit 11 high with a start signal or nonzero output frequency.
// RQ14: Bit 12 high while stopped by temporary overload, auto restart.
// RQ15: Bit 13 high when DC link voltage is outside its limits.
// RQ16: Bit 14 high when torque exceeds motor or generator limit.
// RQ17: Bit 15 high when a thermal timer passes 100 percent.
// RQ18: Link loss or internal communication fault forces the word to zero.
// RQ19: Master must set command bit 10; otherwise the word is ignored.
// RQ20: Word is registered every clock and clears to zero on reset.
`timescale 1ns/1ps
`include "dsw_consts.svh"
module dsw_top import dsw_pkg::*; (
    input wire logic clk_i,
    input wire logic resetn_i,
    // Register port
    input wire logic [`DSW_ADDR_W-1:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [15:0] reg_rdata_o,
    // Command word from the fieldbus master
    input wire logic [15:0] cmd_word_i,
    input wire logic cmd_valid_i,
    // Drive condition flags
    input wire logic trip_i,
    input wire logic power_unit_ok_i,
    input wire logic warning_i,
    input wire logic speed_at_ref_i,
    input wire logic local_stop_i,
    input wire logic ref_site_remote_i,
    input wire logic start_signal_i,
    input wire logic overload_stop_i,
    input wire logic link_lost_i,
    input wire logic comm_fault_i,
    // Measured values
    input wire logic [15:0] actual_output_frequency_value_i,
    input wire logic [15:0] dc_link_voltage_i,
    input wire logic [15:0] torque_i,
    input wire logic [15:0] motor_thermal_i,
    input wire logic [15:0] drive_thermal_i,
    // Results
    output logic [15:0] drive_status_word_o,
    output logic trip_latched_o
);
    dsw_cmd_if cmd_if ();

    dsw_cmd_latch u_latch (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .cmd_word_i(cmd_word_i),
        .cmd_valid_i(cmd_valid_i),
        .cmd_if(cmd_if.latch)
    );

    dsw_start_inhibit u_inhibit (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .cmd_if(cmd_if.inhibit)
    );

    // Software registers
    dsw_word_t ctrl_q;
    dsw_word_t freq_lo_q;
    dsw_word_t freq_hi_q;
    dsw_word_t trq_mot_q;
    dsw_word_t trq_gen_q;
    dsw_word_t dc_lo_q;
    dsw_word_t dc_hi_q;
    logic link_seen_q;
    logic trip_seen_q;
    logic trip_q;
    dsw_word_t status_q;
    dsw_word_t status_d;
    dsw_word_t rdata_q;
    dsw_word_t rdata_d;

    // Address decode
    wire logic wr_ctrl = reg_we_i && (reg_addr_i == `DSW_OFF_CTRL);
    wire logic wr_freq_lo = reg_we_i && (reg_addr_i == `DSW_OFF_FREQ_LO);
    wire logic wr_freq_hi = reg_we_i && (reg_addr_i == `DSW_OFF_FREQ_HI);
    wire logic wr_trq_mot = reg_we_i && (reg_addr_i == `DSW_OFF_TRQ_MOT);
    wire logic wr_trq_gen = reg_we_i && (reg_addr_i == `DSW_OFF_TRQ_GEN);
    wire logic wr_dc_lo = reg_we_i && (reg_addr_i == `DSW_OFF_DC_LO);
    wire logic wr_dc_hi = reg_we_i && (reg_addr_i == `DSW_OFF_DC_HI);
    wire logic wr_events = reg_we_i && (reg_addr_i == `DSW_OFF_EVENTS);

    assign cmd_if.profile_std = ctrl_q[`DSW_CTRL_PROFILE];

    // Command bits as accepted
    wire dsw_word_t cmd = cmd_if.cmd;
    wire logic on1 = cmd[`DSW_CMD_ON1];
    wire logic on2 = cmd[`DSW_CMD_ON2];
    wire logic on3 = cmd[`DSW_CMD_ON3];
    wire logic no_coast = cmd[`DSW_CMD_NOCOAST];
    wire logic all_on = on1 & on2 & on3;

    // Trip stays latched until acknowledged with the cause gone
    wire logic trip_now = trip_i | trip_q;
    wire logic trip_clr = cmd_if.ack_pulse & ~trip_i;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            trip_q <= 1'b0;
        end else if (trip_i) begin
            trip_q <= 1'b1; // RQ5
        end else if (trip_clr) begin
            trip_q <= 1'b0; // RQ5
        end
    end

    // Conditions derived from measured values and drive condition flags
    wire logic freq_ok = dsw_in_window(actual_output_frequency_value_i,
                                       freq_lo_q, freq_hi_q); // RQ12
    wire logic dc_bad = ~dsw_in_window(dc_link_voltage_i, dc_lo_q, dc_hi_q); // RQ15
    wire dsw_word_t trq_mag = dsw_abs(torque_i);
    wire logic trq_mot_over = ~torque_i[15] & (trq_mag > trq_mot_q);
    wire logic trq_gen_over = torque_i[15] & (trq_mag > trq_gen_q);
    wire logic trq_over = trq_mot_over | trq_gen_over; // RQ16
    wire logic thermal_over = (motor_thermal_i > `DSW_THERMAL_FULL)
                            | (drive_thermal_i > `DSW_THERMAL_FULL); // RQ17
    wire logic running = start_signal_i
                       | (actual_output_frequency_value_i != 16'h0000); // RQ13
    wire logic bus_ctrl = ref_site_remote_i & ~local_stop_i; // RQ11
    wire logic link_bad = link_lost_i | comm_fault_i;

    // Status word assembly
    always_comb begin
        status_d = 16'h0000;
        status_d[`DSW_ST_CTRL_RDY] = all_on & ~trip_now; // RQ2
        status_d[`DSW_ST_DRV_RDY] = all_on & ~trip_now & power_unit_ok_i; // RQ3
        status_d[`DSW_ST_ENABLE] = all_on & no_coast & ~trip_now; // RQ4
        status_d[`DSW_ST_TRIP] = trip_now; // RQ5
        status_d[`DSW_ST_ON2] = on2; // RQ6
        status_d[`DSW_ST_ON3] = on3; // RQ7
        status_d[`DSW_ST_INHIBIT] = cmd_if.start_inhibit; // RQ8
        status_d[`DSW_ST_WARN] = warning_i; // RQ9
        status_d[`DSW_ST_SPEED] = speed_at_ref_i; // RQ10
        status_d[`DSW_ST_BUS] = bus_ctrl; // RQ11
        status_d[`DSW_ST_FREQ] = freq_ok; // RQ12
        status_d[`DSW_ST_RUN] = running; // RQ13
        status_d[`DSW_ST_AUTO] = overload_stop_i & ~trip_now; // RQ14
        status_d[`DSW_ST_VOLT] = dc_bad; // RQ15
        status_d[`DSW_ST_TORQUE] = trq_over; // RQ16
        status_d[`DSW_ST_TIMER] = thermal_over; // RQ17
        if (link_bad) begin
            status_d = 16'h0000; // RQ18
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            status_q <= 16'h0000; // RQ20
        end else begin
            status_q <= status_d; // RQ1
        end
    end

    // Configuration registers
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl_q <= `DSW_RST_CTRL;
            freq_lo_q <= `DSW_RST_FREQ_LO;
            freq_hi_q <= `DSW_RST_FREQ_HI;
            trq_mot_q <= `DSW_RST_TRQ;
            trq_gen_q <= `DSW_RST_TRQ;
            dc_lo_q <= `DSW_RST_DC_LO;
            dc_hi_q <= `DSW_RST_DC_HI;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= {15'h0000, reg_wdata_i[`DSW_CTRL_PROFILE]};
            end
            if (wr_freq_lo) begin
                freq_lo_q <= reg_wdata_i;
            end
            if (wr_freq_hi) begin
                freq_hi_q <= reg_wdata_i;
            end
            if (wr_trq_mot) begin
                trq_mot_q <= reg_wdata_i;
            end
            if (wr_trq_gen) begin
                trq_gen_q <= reg_wdata_i;
            end
            if (wr_dc_lo) begin
                dc_lo_q <= reg_wdata_i;
            end
            if (wr_dc_hi) begin
                dc_hi_q <= reg_wdata_i;
            end
        end
    end

    // Sticky event flags, write one to clear; a new event in the clear cycle wins
    wire logic link_seen_d = link_bad
                           | (link_seen_q & ~(wr_events & reg_wdata_i[`DSW_EV_LINK]));
    wire logic trip_seen_d = trip_i
                           | (trip_seen_q & ~(wr_events & reg_wdata_i[`DSW_EV_TRIP]));

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            link_seen_q <= 1'b0;
            trip_seen_q <= 1'b0;
        end else begin
            link_seen_q <= link_seen_d;
            trip_seen_q <= trip_seen_d;
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        rdata_d = 16'h0000;
        if (reg_re_i) begin
            unique case (reg_addr_i)
                `DSW_OFF_STATUS: rdata_d = status_q;
                `DSW_OFF_CTRL: rdata_d = ctrl_q;
                `DSW_OFF_FREQ_LO: rdata_d = freq_lo_q;
                `DSW_OFF_FREQ_HI: rdata_d = freq_hi_q;
                `DSW_OFF_TRQ_MOT: rdata_d = trq_mot_q;
                `DSW_OFF_TRQ_GEN: rdata_d = trq_gen_q;
                `DSW_OFF_DC_LO: rdata_d = dc_lo_q;
                `DSW_OFF_DC_HI: rdata_d = dc_hi_q;
                `DSW_OFF_CMD: rdata_d = cmd;
                `DSW_OFF_EVENTS: rdata_d = {14'h0000, trip_seen_q, link_seen_q};
                default: rdata_d = 16'h0000;
            endcase
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_q <= 16'h0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata_o = rdata_q;
    assign drive_status_word_o = status_q;
    assign trip_latched_o = trip_q;
endmodule // dsw_top

// ===== sim/dsw_checker.sv
// Port checks of the drive status word builder
`timescale 1ns/1ps
`include "dsw_consts.svh"
module dsw_checker (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [15:0] cmd_word_i,
    input wire logic cmd_valid_i,
    input wire logic trip_i,
    input wire logic power_unit_ok_i,
    input wire logic link_lost_i,
    input wire logic comm_fault_i,
    input wire logic [15:0] motor_thermal_i,
    input wire logic [15:0] drive_thermal_i,
    input wire logic [15:0] drive_status_word_o,
    input wire logic trip_latched_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);
    logic [15:0] acc_q;
    logic ok_q;
    wire link_bad = link_lost_i | comm_fault_i;
    wire trip_now = trip_i | trip_latched_o;
    wire rdy_now = &acc_q[2:0] & ~trip_now;
    wire hot_now = (motor_thermal_i > `DSW_THERMAL_FULL) | (drive_thermal_i > `DSW_THERMAL_FULL);
    wire ack_now = cmd_valid_i & cmd_word_i[`DSW_CMD_VALID] & cmd_word_i[`DSW_CMD_RESET];
    wire [15:0] st = drive_status_word_o;
    // Own copy of the accepted word; ok_q also masks the first edge after reset
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            acc_q <= 16'h0000;
            ok_q <= 1'b0;
        end else begin
            ok_q <= ~link_bad;
            if (cmd_valid_i && cmd_word_i[`DSW_CMD_VALID]) begin
                acc_q <= cmd_word_i;
            end
        end
    end
    link_zero_a: assert property (link_bad |=> st == 16'h0000)
        else $error("word not cleared on link fault");
    coast_mirror_a: assert property (ok_q |-> st[4] == $past(acc_q[1]))
        else $error("bit 4 mirror wrong");
    quick_mirror_a: assert property (ok_q |-> st[5] == $past(acc_q[2]))
        else $error("bit 5 mirror wrong");
    ready_bit_a: assert property (ok_q |-> st[0] == $past(rdy_now))
        else $error("bit 0 wrong");
    drive_ready_a: assert property (ok_q |-> st[1] == (st[0] && $past(power_unit_ok_i)))
        else $error("bit 1 wrong");
    trip_bit_a: assert property (ok_q |-> st[3] == $past(trip_now))
        else $error("bit 3 wrong");
    trip_hold_a: assert property ($fell(trip_latched_o) |-> !$past(trip_i) &&
        ($past(ack_now, 2) || $past(ack_now, 3) || $past(ack_now, 4))) else $error("trip lost");
    timer_bit_a: assert property (ok_q |-> st[15] == $past(hot_now))
        else $error("bit 15 wrong");
    cover property ($fell(trip_latched_o));
    cover property (ok_q && $fell(st[6]));
    cover property (link_bad ##1 st == 16'h0000);
endmodule // dsw_checker

// ===== sim/dsw_master_model.sv
// Fieldbus master model sending command telegrams
`timescale 1ns/1ps
module dsw_master_model (
    input wire logic clk_i,
    output logic [15:0] cmd_word_o,
    output logic cmd_valid_o
);
    initial begin
        cmd_word_o = 16'hffff;
        cmd_valid_o = 1'b0;
    end
    // Lines show the inverse between telegrams so the stale word of a telegram sent as valid never looks valid
    task automatic send(input logic [15:0] bits, input logic valid);
        cmd_word_o <= {bits[15:11], valid, bits[9:0]};
        cmd_valid_o <= 1'b1;
        @(posedge clk_i);
        cmd_word_o <= ~{bits[15:11], valid, bits[9:0]};
        cmd_valid_o <= 1'b0;
        @(posedge clk_i);
    endtask
endmodule // dsw_master_model

// ===== sim/dsw_top_tb.sv
// Self-checking bench of the drive status word builder
`timescale 1ns/1ps
`include "dsw_consts.svh"
module dsw_top_tb import dsw_pkg::*;;
    logic clk_i = 1'b0, resetn_i = 1'b0, reg_we_i = 1'b0, reg_re_i = 1'b0;
    logic [`DSW_ADDR_W-1:0] reg_addr_i = '0;
    logic [15:0] reg_wdata_i = '0, reg_rdata_o, drive_status_word_o, cmd_word_i, rd;
    logic cmd_valid_i, trip_latched_o, trip_i = 0, power_unit_ok_i = 0, warning_i = 0;
    logic speed_at_ref_i = 0, local_stop_i = 0, ref_site_remote_i = 0, start_signal_i = 0;
    logic overload_stop_i = 0, link_lost_i = 0, comm_fault_i = 0;
    logic [15:0] actual_output_frequency_value_i = '0, dc_link_voltage_i = '0, torque_i = '0;
    logic [15:0] motor_thermal_i = '0, drive_thermal_i = '0;
    logic [15:0] acc = '0, dlo = `DSW_RST_DC_LO, dhi = `DSW_RST_DC_HI;
    logic [15:0] flo = `DSW_RST_FREQ_LO, fhi = `DSW_RST_FREQ_HI, tmot = `DSW_RST_TRQ;
    logic lat = 1'b0, inh = 1'b1, prof = 1'b1;
    logic [15:0] rst_tab [8] = '{`DSW_RST_CTRL, `DSW_RST_FREQ_LO, `DSW_RST_FREQ_HI,
        `DSW_RST_TRQ, `DSW_RST_TRQ, `DSW_RST_DC_LO, `DSW_RST_DC_HI, 16'h0000};
    logic [15:0] seq [5] = '{16'h040f, 16'h0406, 16'h0407, 16'h0403, 16'h0405};
    int errors = 0, check_count = 0, cyc = 0;
    dsw_top i_dsw_top (.clk_i, .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i,
        .reg_rdata_o, .cmd_word_i, .cmd_valid_i, .trip_i, .power_unit_ok_i, .warning_i,
        .speed_at_ref_i, .local_stop_i, .ref_site_remote_i, .start_signal_i, .overload_stop_i,
        .link_lost_i, .comm_fault_i, .actual_output_frequency_value_i, .dc_link_voltage_i,
        .torque_i, .motor_thermal_i, .drive_thermal_i, .drive_status_word_o, .trip_latched_o);
    dsw_master_model i_dsw_master_model (.clk_i, .cmd_word_o(cmd_word_i),
        .cmd_valid_o(cmd_valid_i));
    always #10 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            test_done();
        end
    end
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s exp %h seen %h", name, exp, seen);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_we_i <= 1'b1;
        @(posedge clk_i);
        reg_we_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic reg_rd(input logic [7:0] a, output logic [15:0] d);
        reg_addr_i <= a;
        reg_re_i <= 1'b1;
        @(posedge clk_i);
        reg_re_i <= 1'b0;
        @(negedge clk_i);
        d = reg_rdata_o;
        @(posedge clk_i);
    endtask
    // Model state follows only accepted words, as the block ignores the rest
    task automatic cmd(input logic [15:0] bits, input logic v);
        logic ack;
        ack = v & bits[7] & ~acc[7];
        i_dsw_master_model.send(bits, v);
        if (v) acc = bits | 16'h0400;
        if (ack && !trip_i) lat = 1'b0;
        if (!acc[1] || !acc[2]) inh = 1'b1;
        else if (!acc[0]) inh = 1'b0;
        else if (ack) inh = 1'b1;
    endtask
    function automatic logic in_lim(input logic [15:0] v, input logic [15:0] lo, hi);
        return $signed(v) >= $signed(lo) && $signed(v) <= $signed(hi);
    endfunction
    function automatic dsw_word_t model();
        dsw_word_t w;
        logic tr;
        int tq;
        tr = trip_i | lat;
        tq = int'($signed(torque_i));
        w[0] = &acc[2:0] & ~tr;
        w[1] = w[0] & power_unit_ok_i;
        w[2] = w[0] & acc[3];
        w[3] = tr;
        w[5:4] = acc[2:1];
        w[6] = inh & prof;
        w[8:7] = {speed_at_ref_i, warning_i};
        w[9] = ref_site_remote_i & ~local_stop_i;
        w[10] = in_lim(actual_output_frequency_value_i, flo, fhi);
        w[11] = start_signal_i | (actual_output_frequency_value_i != 16'h0000);
        w[12] = overload_stop_i & ~tr;
        w[13] = !in_lim(dc_link_voltage_i, dlo, dhi);
        w[14] = (tq < 0) ? (-tq > int'(`DSW_RST_TRQ)) : (tq > int'(tmot));
        w[15] = motor_thermal_i > 16'h0064 || drive_thermal_i > 16'h0064;
        return (link_lost_i | comm_fault_i) ? 16'h0000 : w;
    endfunction
    task automatic settle();
        repeat (4) @(posedge clk_i);
        if (trip_i) lat = 1'b1;
        @(negedge clk_i);
        check("status word", drive_status_word_o, model());
        check("trip latch", 16'(trip_latched_o), 16'(lat));
        @(posedge clk_i);
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        void'($urandom(32'hd42948fd));
        repeat (2) @(posedge clk_i);
        check("reset word", drive_status_word_o, 16'h0000);
        resetn_i <= 1'b1;
        settle();
        for (int k = 0; k < 8; k++) begin
            reg_rd(8'(4 * k + 4), rd);
            check("register reset", rd, rst_tab[k]);
        end
        reg_rd(8'h30, rd);
        check("unmapped read", rd, 16'h0000);
        reg_wr(`DSW_OFF_STATUS, 16'hffff);
        reg_wr(`DSW_OFF_CMD, 16'hffff);
        reg_wr(`DSW_OFF_DC_LO, 16'h0100);
        reg_wr(`DSW_OFF_DC_HI, 16'h7000);
        dlo = 16'h0100;
        dhi = 16'h7000;
        // Asymmetric limits so each window and each torque sign is told apart
        reg_wr(`DSW_OFF_FREQ_LO, 16'hf000);
        reg_wr(`DSW_OFF_FREQ_HI, 16'h2000);
        reg_wr(`DSW_OFF_TRQ_MOT, 16'h1000);
        flo = 16'hf000;
        fhi = 16'h2000;
        tmot = 16'h1000;
        power_unit_ok_i <= 1'b1;
        foreach (seq[k]) begin
            cmd(seq[k], 1'b1);
            settle();
        end
        cmd(16'h0406, 1'b0);
        settle();
        reg_rd(`DSW_OFF_CMD, rd);
        check("accepted word", rd, acc);
        trip_i <= 1'b1;
        settle();
        trip_i <= 1'b0;
        settle();
        cmd(16'h048f, 1'b1);
        settle();
        reg_wr(`DSW_OFF_CTRL, 16'h0000);
        prof = 1'b0;
        settle();
        reg_wr(`DSW_OFF_CTRL, 16'h0001);
        prof = 1'b1;
        comm_fault_i <= 1'b1;
        settle();
        comm_fault_i <= 1'b0;
        reg_rd(`DSW_OFF_EVENTS, rd);
        check("event flags", rd, 16'h0003);
        reg_wr(`DSW_OFF_EVENTS, 16'h0003);
        reg_rd(`DSW_OFF_EVENTS, rd);
        check("event clear", rd, 16'h0000);
        for (int n = 0; n < 80; n++) begin
            {warning_i, speed_at_ref_i, local_stop_i, ref_site_remote_i} <= 4'($urandom);
            {start_signal_i, overload_stop_i, power_unit_ok_i} <= 3'($urandom);
            trip_i <= ($urandom_range(7) == 0);
            link_lost_i <= ($urandom_range(15) == 0);
            actual_output_frequency_value_i <= 16'($urandom);
            dc_link_voltage_i <= 16'($urandom);
            torque_i <= 16'($urandom) | 16'h0001;
            motor_thermal_i <= 16'($urandom_range(102, 99));
            drive_thermal_i <= 16'($urandom_range(101));
            @(posedge clk_i);
            cmd(16'($urandom), 1'($urandom));
            settle();
        end
        test_done();
    end
endmodule // dsw_top_tb
bind dsw_top dsw_checker i_dsw_checker (.clk_i, .resetn_i, .cmd_word_i, .cmd_valid_i, .trip_i,
    .power_unit_ok_i, .link_lost_i, .comm_fault_i, .motor_thermal_i, .drive_thermal_i,
    .drive_status_word_o, .trip_latched_o);
